// File: logic/capcmp_defines.vh
/*
 * register map, field positions and reset values of the capture / compare block.
 * assumes an apb master with 32-bit data and word-aligned addresses.
 */
`ifndef CAPCMP_DEFINES_VH
`define CAPCMP_DEFINES_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define A_CAP_EDGE      8'h00
`define A_CAP_VAL0      8'h04
`define A_CAP_VAL1      8'h08
`define A_CAP_VAL2      8'h0C
`define A_CAP_VAL3      8'h10
`define A_SET_MATCH     8'h14
`define A_RESET_MATCH   8'h18
`define A_TOGGLE_MATCH  8'h1C
`define A_SET_EN        8'h20
`define A_RESET_EN      8'h24
`define A_FLAGS         8'h28
`define A_FLAG_MASK     8'h2C
`define A_TIMER         8'h30
`define A_TIMER_CTRL    8'h34
`define A_OUT_STATE     8'h38

// ----------------------------------------
// fields and widths
// ----------------------------------------
`define ADDR_W          8
`define CAP_N           4
`define SR_N            6
`define TOG_A_BIT       6
`define TOG_B_BIT       7
`define FLAG_N          7
`define FLAG_SET_BIT    4
`define FLAG_RESET_BIT  5
`define FLAG_TOG_BIT    6
`define PHASES          12
`define PHASE_W         4
`define PHASE_LAST      4'hB

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000
`define RST_EDGE        8'h00
`define RST_FLAGS       7'h00
`define ZERO32          32'h00000000

`endif

// File: logic/timer_capture_compare_outputs.v
/*
 * capture / compare block on a free-running 16-bit timer, apb register slave.
 * assumes capture pins are asynchronous to pclk; the machine cycle is an
 * internal divide-by-twelve of pclk; outputs drive a port mux outside.
 */
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "capcmp_defines.vh"

module timer_capture_compare_outputs (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [3:0] capture_in,
    output reg [5:0] setreset_out,
    output reg toggle_output_a,
    output reg toggle_output_b,
    output reg irq_q
);

    // ----------------------------------------
    // machine cycle phase divider
    // ----------------------------------------
    // twelve pclk make one machine cycle: phase 0 samples and compares,
    // the last phase moves the count and loads the captures
    reg [`PHASE_W-1:0] phase_q;
    wire state_one_phase_one;
    assign state_one_phase_one = (phase_q == {`PHASE_W{1'b0}});
    wire cycle_end;
    assign cycle_end = (phase_q == `PHASE_LAST);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= {`PHASE_W{1'b0}};
        end else if (cycle_end) begin
            phase_q <= {`PHASE_W{1'b0}};
        end else begin
            phase_q <= phase_q + 4'h1;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] capture_edge_control_q;
    reg [15:0] cap_val_q [0:`CAP_N-1];
    reg [15:0] set_match_value_q;
    reg [15:0] reset_match_value_q;
    reg [15:0] toggle_match_value_q;
    // only the six writable enables live here; the two upper bits of that
    // register read back the toggle flops
    reg [5:0] set_enable_q;
    reg [7:0] reset_and_toggle_enable_q;
    reg [`FLAG_N-1:0] timer_interrupt_flags_q;
    reg [`FLAG_N-1:0] flag_mask_q;
    reg [15:0] timer_q;
    reg timer_run_q;
    reg tog_a_q;
    reg tog_b_q;

    wire wr_en;
    assign wr_en = psel && penable && pwrite && pready;

    // ----------------------------------------
    // timer
    // ----------------------------------------
    // the count advances once per machine cycle, at its last phase, so
    // matches and captures inside a cycle all see one stable value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_q <= `RST_WORD;
        end else if (timer_run_q && cycle_end) begin
            timer_q <= timer_q + 16'h0001;
        end
    end

    // a match only counts in the first phase after the count moved: a stopped
    // timer parked on a match value must not pulse every machine cycle
    // limitation: a match value equal to the count at the moment it is written
    // hits only when the count comes round again
    // no software write path to the count: only reset clears it
    reg count_moved_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_moved_q <= 1'b0;
        end else begin
            count_moved_q <= timer_run_q && cycle_end;
        end
    end

    // ----------------------------------------
    // capture inputs
    // ----------------------------------------
    // two flops per pin: the pins are asynchronous to pclk
    reg [3:0] cap_sync1_q;
    reg [3:0] cap_sync2_q;
    reg [3:0] cap_now_q;
    reg [3:0] cap_hit_q;
    // the first sample after reset holds the synchroniser's reset value, not
    // the pin; edges are judged from the third sample on, or an input that
    // idles high would fake a rise right after reset
    reg [1:0] cap_primed_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_sync1_q <= 4'h0;
            cap_sync2_q <= 4'h0;
        end else begin
            cap_sync1_q <= capture_in;
            cap_sync2_q <= cap_sync1_q;
        end
    end

    function [3:0] edge_select;
        input [3:0] now;
        input [3:0] prev;
        input [7:0] ctrl;
        integer k;
        begin
            edge_select = 4'h0;
            for (k = 0; k < `CAP_N; k = k + 1) begin
                // rise: even control bit, fall: odd control bit
                edge_select[k] = (now[k] & ~prev[k] & ctrl[2*k]) | (~now[k] & prev[k] & ctrl[2*k+1]);
            end
        end
    endfunction

    // one sample per cycle
    // sampled once per machine cycle; the detected edge is held until the
    // cycle's end so the load uses the count of that same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_now_q <= 4'h0;
            cap_hit_q <= 4'h0;
            cap_primed_q <= 2'b00;
        end else if (state_one_phase_one) begin
            cap_now_q <= cap_sync2_q;
            cap_primed_q <= {cap_primed_q[0], 1'b1};
            cap_hit_q <= cap_primed_q[1] ? edge_select(cap_sync2_q, cap_now_q, capture_edge_control_q) : 4'h0;
        end else if (cycle_end) begin
            cap_hit_q <= 4'h0;
        end
    end

    integer ci;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (ci = 0; ci < `CAP_N; ci = ci + 1) begin
                cap_val_q[ci] <= `RST_WORD;
            end
        end else if (cycle_end) begin
            for (ci = 0; ci < `CAP_N; ci = ci + 1) begin
                if (cap_hit_q[ci]) begin
                    cap_val_q[ci] <= timer_q;
                end
            end
        end
    end

    // ----------------------------------------
    // compare
    // ----------------------------------------
    // continuous compare
    // pulses fire once per machine cycle, in its first phase, so a match
    // that holds for the whole count value still yields one pulse
    wire set_pulse;
    wire reset_pulse;
    wire tog_pulse;
    wire match_slot;
    assign match_slot = state_one_phase_one && count_moved_q;
    assign set_pulse = match_slot && (timer_q == set_match_value_q);
    assign reset_pulse = match_slot && (timer_q == reset_match_value_q);
    assign tog_pulse = match_slot && (timer_q == toggle_match_value_q);

    wire [`SR_N-1:0] sr_set;
    wire [`SR_N-1:0] sr_clr;
    assign sr_set = {`SR_N{set_pulse}} & set_enable_q;
    assign sr_clr = {`SR_N{reset_pulse}} & reset_and_toggle_enable_q[`SR_N-1:0];

    // six set/reset outputs
    // set wins when both matches hit the same output in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setreset_out <= 6'h00;
        end else begin
            setreset_out <= (setreset_out & ~sr_clr) | sr_set;
        end
    end

    // no software write
    // cleared by reset only so the state read back is defined; software
    // should still check it against the wanted phase before relying on it
    wire tog_a_hit;
    wire tog_b_hit;
    assign tog_a_hit = tog_pulse && reset_and_toggle_enable_q[`TOG_A_BIT];
    assign tog_b_hit = tog_pulse && reset_and_toggle_enable_q[`TOG_B_BIT];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog_a_q <= 1'b0;
            tog_b_q <= 1'b0;
            toggle_output_a <= 1'b0;
            toggle_output_b <= 1'b0;
        end else begin
            if (tog_a_hit) begin
                tog_a_q <= ~tog_a_q;
            end
            if (tog_b_hit) begin
                tog_b_q <= ~tog_b_q;
            end
            toggle_output_a <= tog_a_q;
            toggle_output_b <= tog_b_q;
        end
    end

    // ----------------------------------------
    // flags and interrupt
    // ----------------------------------------
    // a capture flag rises with the load, at the end of the cycle
    wire [`CAP_N-1:0] cap_load;
    assign cap_load = cycle_end ? cap_hit_q : 4'h0;
    wire [`FLAG_N-1:0] flag_events;
    assign flag_events = {tog_pulse, reset_pulse, set_pulse, cap_load};

    // only a write to the flag register's own address may clear flags
    wire [`FLAG_N-1:0] flag_clear;
    assign flag_clear = (wr_en && (paddr == `A_FLAGS)) ? pwdata[`FLAG_N-1:0] : `RST_FLAGS;

    // sticky, write one to clear
    // set has priority over a clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_interrupt_flags_q <= `RST_FLAGS;
        end else begin
            timer_interrupt_flags_q <= (timer_interrupt_flags_q & ~flag_clear) | flag_events;
        end
    end

    // per-flag mask
    // registered so the request never glitches while flags and mask change
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(timer_interrupt_flags_q & flag_mask_q);
        end
    end

    // ----------------------------------------
    // apb writes
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_edge_control_q <= `RST_EDGE;
            set_match_value_q <= `RST_WORD;
            reset_match_value_q <= `RST_WORD;
            toggle_match_value_q <= `RST_WORD;
            set_enable_q <= 6'h00;
            reset_and_toggle_enable_q <= `RST_BYTE;
            flag_mask_q <= `RST_FLAGS;
            timer_run_q <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `A_CAP_EDGE: capture_edge_control_q <= pwdata[7:0];
                `A_SET_MATCH: set_match_value_q <= pwdata[15:0];
                `A_RESET_MATCH: reset_match_value_q <= pwdata[15:0];
                `A_TOGGLE_MATCH: toggle_match_value_q <= pwdata[15:0];
                // bits 7:6 are read-only toggle states
                `A_SET_EN: set_enable_q <= pwdata[5:0];
                `A_RESET_EN: reset_and_toggle_enable_q <= pwdata[7:0];
                `A_FLAG_MASK: flag_mask_q <= pwdata[`FLAG_N-1:0];
                `A_TIMER_CTRL: timer_run_q <= pwdata[0];
                // unmapped and read-only addresses are dropped here
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // apb reads and handshake
    // ----------------------------------------
    // addresses past the end of the map and unaligned addresses answer with an error
    function mapped;
        input [7:0] a;
        begin
            mapped = (a <= `A_OUT_STATE) && (a[1:0] == 2'b00);
        end
    endfunction

    reg [31:0] rd_d;
    always @* begin
        rd_d = `ZERO32;
        case (paddr)
            `A_CAP_EDGE: rd_d = {24'h000000, capture_edge_control_q};
            `A_CAP_VAL0: rd_d = {16'h0000, cap_val_q[0]};
            `A_CAP_VAL1: rd_d = {16'h0000, cap_val_q[1]};
            `A_CAP_VAL2: rd_d = {16'h0000, cap_val_q[2]};
            `A_CAP_VAL3: rd_d = {16'h0000, cap_val_q[3]};
            `A_SET_MATCH: rd_d = {16'h0000, set_match_value_q};
            `A_RESET_MATCH: rd_d = {16'h0000, reset_match_value_q};
            `A_TOGGLE_MATCH: rd_d = {16'h0000, toggle_match_value_q};
            `A_SET_EN: rd_d = {24'h000000, tog_b_q, tog_a_q, set_enable_q};
            `A_RESET_EN: rd_d = {24'h000000, reset_and_toggle_enable_q};
            `A_FLAGS: rd_d = {25'h0000000, timer_interrupt_flags_q};
            `A_FLAG_MASK: rd_d = {25'h0000000, flag_mask_q};
            `A_TIMER: rd_d = {16'h0000, timer_q};
            `A_TIMER_CTRL: rd_d = {31'h00000000, timer_run_q};
            `A_OUT_STATE: rd_d = {24'h000000, toggle_output_b, toggle_output_a, setreset_out};
            default: rd_d = `ZERO32;
        endcase
    end

    // one wait state: pready rises after the first access cycle, then drops
    // prdata is rewritten on every access (zero for writes), held between
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `ZERO32;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !mapped(paddr);
            prdata <= pwrite ? `ZERO32 : rd_d;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // timer_capture_compare_outputs

// File: dv/event_source.sv
/*
 * far-side model: drives the four capture pins from a level request.
 * assumes the bench changes the request at most once per few machine cycles.
 */
`timescale 1ns/1ps
// ----------------------------------------
// capture pin driver
// ----------------------------------------
module event_source (
    input wire pclk,
    input wire [3:0] level_req,
    output logic [3:0] capture_in = 4'h0
);
    // held levels
    // pins move only after an edge, so each per-cycle sample sees a clean level
    always @(posedge pclk) begin
        capture_in <= level_req;
    end
endmodule // event_source

// File: dv/capcmp_properties.sv
/*
 * checker on the ports of the capture / compare block.
 * assumes the apb master keeps its request until pready.
 */
`timescale 1ns/1ps
`include "capcmp_defines.vh"
module capcmp_properties (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [3:0] capture_in,
    input wire [5:0] setreset_out,
    input wire toggle_output_a,
    input wire toggle_output_b,
    input wire irq_q
);
    // ----------------------------------------
    // apb and output timing
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_quiet;
        $stable(setreset_out) [*8];
    endsequence
    sequence s_tog_quiet;
        $stable({toggle_output_b, toggle_output_a}) [*8];
    endsequence
    a_ready_wait: assert property (s_access |=> pready)
        else $error("no ready after access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_inside: assert property (pready |-> psel && penable)
        else $error("ready outside a transfer");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_unmapped: assert property (s_access ##0 (paddr > `A_OUT_STATE) |=> pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (s_access ##0 (paddr <= `A_OUT_STATE && paddr[1:0] == 2'h0) |=> !pslverr)
        else $error("mapped access refused");
    a_rdata_hold: assert property (!(psel && penable && !pready) |=> $stable(prdata))
        else $error("read data moved without a read");
    a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("refused read not zero");
    // after a change, the set/reset outputs, and the toggle outputs, must hold for the next eight pclk
    a_sr_spacing: assert property ($changed(setreset_out) |=> s_quiet)
        else $error("outputs changed twice in a machine cycle");
    a_tog_spacing: assert property ($changed({toggle_output_b, toggle_output_a}) |=> s_tog_quiet)
        else $error("toggle outputs changed twice in a machine cycle");
endmodule // capcmp_properties

bind timer_capture_compare_outputs capcmp_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_in(capture_in), .setreset_out(setreset_out),
    .toggle_output_a(toggle_output_a), .toggle_output_b(toggle_output_b), .irq_q(irq_q));

// File: dv/tb.sv
/*
 * self-checking bench for the capture / compare block over apb.
 * assumes the machine cycle is twelve pclk and the timer starts stopped.
 */
`timescale 1ns/1ps
`include "capcmp_defines.vh"
module tb;
    // ----------------------------------------
    // stimulus and checking
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] level_req = 4'h0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [3:0] capture_in;
    wire [5:0] setreset_out;
    wire toggle_output_a;
    wire toggle_output_b;
    wire irq_q;
    int miscompares = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic err;
    logic [15:0] t;

    always #20 pclk = ~pclk;

    timer_capture_compare_outputs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_in(capture_in), .setreset_out(setreset_out),
        .toggle_output_a(toggle_output_a), .toggle_output_b(toggle_output_b), .irq_q(irq_q));
    event_source far (.pclk(pclk), .level_req(level_req), .capture_in(capture_in));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one transfer; the wait ends only on pready or the watchdog
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wrap_up;
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task t_reset;
        apb(1'b0, `A_CAP_EDGE, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `A_FLAGS, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, `A_TIMER, 32'h1234);
        apb(1'b0, `A_TIMER, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        check({31'h0, err}, 32'h1);
        check(setreset_out, 32'h0);
    endtask

    task t_compare;
        int n;
        apb(1'b1, `A_SET_MATCH, 32'h3);
        apb(1'b1, `A_RESET_MATCH, 32'h6);
        apb(1'b1, `A_TOGGLE_MATCH, 32'h4);
        apb(1'b1, `A_SET_EN, 32'hC5);
        apb(1'b1, `A_RESET_EN, 32'h44);
        apb(1'b1, `A_FLAG_MASK, 32'h10);
        apb(1'b0, `A_SET_EN, 32'h0);
        check(rd, 32'h05);
        apb(1'b0, `A_RESET_EN, 32'h0);
        check(rd, 32'h44);
        apb(1'b1, `A_TIMER_CTRL, 32'h1);
        n = 0;
        while (setreset_out === 6'h00 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        check(setreset_out, 32'h05);
        repeat (120) @(posedge pclk);
        check(setreset_out, 32'h01);
        check(irq_q, 32'h1);
        check(toggle_output_a, 32'h1);
        check(toggle_output_b, 32'h0);
        apb(1'b0, `A_SET_EN, 32'h0);
        check(rd, 32'h45);
        apb(1'b0, `A_OUT_STATE, 32'h0);
        check(rd, 32'h41);
        apb(1'b0, `A_FLAGS, 32'h0);
        check(rd, 32'h70);
        apb(1'b1, `A_FLAGS, 32'h10);
        apb(1'b0, `A_FLAGS, 32'h0);
        check(rd, 32'h60);
        check(irq_q, 32'h0);
        apb(1'b1, `A_TIMER_CTRL, 32'h0);
    endtask

    // timer is stopped so every capture must hold exactly t
    task t_capture;
        apb(1'b0, `A_TIMER, 32'h0);
        t = rd[15:0];
        apb(1'b1, `A_FLAGS, 32'h7F);
        apb(1'b1, `A_CAP_EDGE, 32'h39);
        level_req <= 4'hF;
        repeat (40) @(posedge pclk);
        apb(1'b0, `A_FLAGS, 32'h0);
        check(rd, 32'h05);
        apb(1'b0, `A_CAP_VAL0, 32'h0);
        check(rd, {16'h0000, t});
        apb(1'b0, `A_CAP_VAL2, 32'h0);
        check(rd, {16'h0000, t});
        apb(1'b1, `A_FLAGS, 32'h7F);
        level_req <= 4'h0;
        repeat (40) @(posedge pclk);
        apb(1'b0, `A_FLAGS, 32'h0);
        check(rd, 32'h06);
        apb(1'b0, `A_CAP_VAL1, 32'h0);
        check(rd, {16'h0000, t});
        apb(1'b0, `A_CAP_VAL3, 32'h0);
        check(rd, 32'h0);
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_compare;
        t_capture;
        wrap_up;
    end

    initial begin
        #800000;
        miscompares++;
        wrap_up;
    end
endmodule // tb
